// ===== src/srb_smbus_regs.sv
// Two-wire bus slave giving indexed block access to the readback register bank.
`timescale 1ns/100ps
`default_nettype none
`include "srb_params.svh"

module srb_smbus_regs #(
  parameter logic [6:0] DEV_ADDR      = 7'h6A,  // Arbitrary bus address.
  parameter logic [3:0] REVISION_CODE = 4'h3,   // Arbitrary value.
  parameter logic [3:0] VENDOR_CODE   = 4'h6,   // Arbitrary value.
  parameter logic [7:0] PART_CODE     = 8'h5A   // Arbitrary value.
) (
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    SCL,
  input  wire logic                    SDA_IN,
  output logic                         SDA_OUT,
  output logic                         SDA_OE,
  input  wire srb_pkg::srb_pin_level_t PIN_LEVEL,
  output logic [`SRB_READ_LEN_W-1:0]   READ_LENGTH
);
  import srb_pkg::*;

  logic       rst_meta_reg;
  logic       rst_n;
  logic       scl_q_reg;
  logic       scl_d_reg;
  logic       sda_q_reg;
  logic       sda_d_reg;
  srb_state_t state_reg;
  srb_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic       rw_reg;
  logic       rw_next;
  logic       ackok_reg;
  logic       ackok_next;
  srb_write_t wr_reg;
  srb_write_t wr_next;
  logic [7:0] rd_data;
  logic [`SRB_READ_LEN_W-1:0] read_len;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_full;
  logic       ack_state;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Bus lines are synchronous; one stage gives a history for edge finding.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_q_reg <= SCL;
      scl_d_reg <= scl_q_reg;
      sda_q_reg <= SDA_IN;
      sda_d_reg <= sda_q_reg;
    end
  end

  // Clock edges and start or stop conditions while the clock is high.
  assign scl_rise  = scl_q_reg && !scl_d_reg;
  assign scl_fall  = !scl_q_reg && scl_d_reg;
  assign start_det = scl_q_reg && scl_d_reg && sda_d_reg && !sda_q_reg;
  assign stop_det  = scl_q_reg && scl_d_reg && !sda_d_reg && sda_q_reg;
  assign byte_full = (bit_cnt_reg == `SRB_BITS_PER_BYTE);
  assign ack_state = (state_reg == SRB_ADDR_ACK) ||
                     (state_reg == SRB_INDEX_ACK) ||
                     (state_reg == SRB_WCNT_ACK) ||
                     (state_reg == SRB_WDATA_ACK);

  // Open-drain data: we only ever pull low, for an ack or a zero bit.
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = ack_state || ((state_reg == SRB_TX) && !tx_reg[7]);
  assign READ_LENGTH = read_len;

  // Transaction sequencing; data changes only after a falling clock edge.
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    index_next   = index_reg;
    tx_next      = tx_reg;
    rw_next      = rw_reg;
    ackok_next   = ackok_reg;
    wr_next      = '0;
    if (stop_det) begin
      state_next = SRB_IDLE;
    end else if (start_det) begin
      // A repeated start keeps the index set by the write phase.
      state_next   = SRB_ADDR;
      bit_cnt_next = `SRB_BIT_CNT_ZERO;
    end else begin
      case (state_reg)
        SRB_ADDR, SRB_INDEX, SRB_WCNT, SRB_WDATA: begin
          if (scl_rise && !byte_full) begin
            shift_next   = {shift_reg[6:0], sda_q_reg};
            bit_cnt_next = 4'(bit_cnt_reg + `SRB_BIT_CNT_ONE);
          end else if (scl_fall && byte_full) begin
            bit_cnt_next = `SRB_BIT_CNT_ZERO;
            if (state_reg == SRB_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                state_next = SRB_ADDR_ACK;
                rw_next    = shift_reg[0];
              end else begin
                state_next = SRB_WAIT;
              end
            end else if (state_reg == SRB_INDEX) begin
              state_next = SRB_INDEX_ACK;
              index_next = shift_reg;
            end else if (state_reg == SRB_WCNT) begin
              state_next = SRB_WCNT_ACK;
            end else begin
              // the bank drops writes to read-only or reserved bits.
              state_next = SRB_WDATA_ACK;
              wr_next    = '{en: 1'b1, index: index_reg, data: shift_reg};
              index_next = 8'(index_reg + `SRB_INDEX_STEP);
            end
          end
        end
        SRB_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              // the length value goes out first.
              state_next   = SRB_TX;
              tx_next      = 8'(read_len);
              bit_cnt_next = `SRB_BIT_CNT_ZERO;
            end else begin
              state_next = SRB_INDEX;
            end
          end
        end
        SRB_INDEX_ACK: begin
          if (scl_fall) begin
            state_next = SRB_WCNT;
          end
        end
        SRB_WCNT_ACK, SRB_WDATA_ACK: begin
          if (scl_fall) begin
            state_next = SRB_WDATA;
          end
        end
        SRB_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `SRB_LAST_TX_BIT) begin
              state_next   = SRB_TX_ACK;
              bit_cnt_next = `SRB_BIT_CNT_ZERO;
            end else begin
              tx_next      = {tx_reg[6:0], 1'b0};
              bit_cnt_next = 4'(bit_cnt_reg + `SRB_BIT_CNT_ONE);
            end
          end
        end
        SRB_TX_ACK: begin
          if (scl_rise) begin
            ackok_next = !sda_q_reg;
          end else if (scl_fall) begin
            // continue from the index until a not-acknowledge.
            if (ackok_reg) begin
              state_next = SRB_TX;
              tx_next    = rd_data;
              index_next = 8'(index_reg + `SRB_INDEX_STEP);
            end else begin
              state_next = SRB_WAIT;
            end
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= SRB_IDLE;
      bit_cnt_reg <= `SRB_BIT_CNT_ZERO;
      shift_reg   <= `SRB_BYTE_ZERO;
      index_reg   <= `SRB_BYTE_ZERO;
      tx_reg      <= `SRB_BYTE_ZERO;
      rw_reg      <= 1'b0;
      ackok_reg   <= 1'b0;
      wr_reg      <= '0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      index_reg   <= index_next;
      tx_reg      <= tx_next;
      rw_reg      <= rw_next;
      ackok_reg   <= ackok_next;
      wr_reg      <= wr_next;
    end
  end

  // Register bank; reads are combinational so live pins are never stale.
  srb_reg_bank #(
    .REVISION_CODE (REVISION_CODE),
    .VENDOR_CODE   (VENDOR_CODE),
    .PART_CODE     (PART_CODE)
  ) u_bank (
    .clk       (CLK),
    .rst_n     (rst_n),
    .pin_level (PIN_LEVEL),
    .wr        (wr_reg),
    .rd_index  (index_reg),
    .rd_data   (rd_data),
    .read_len  (read_len)
  );

endmodule
`default_nettype wire

// ===== src/srb_params.svh
// Register indices, reset values and bit counts of the readback register bank.
// Functional notes
// - Every implemented bit of the pin readback byte is read-only and shows the live level of its enable pin, 0 low and 1 high.
// - Pin readback bits map groups 5,6,7,8 to bits 0..3 and 10,11,12 to bits 5..7, with bit 4 reserved and reading zero.
// - The identification byte is read-only and returns a fixed revision code in bits 7..4 and a fixed vendor code in bits 3..0.
// - The part identification byte at the next index is read-only and returns a fixed eight-bit part code, bit 7 most significant.
// - The read-length register holds a writable five-bit field in bits 4..0 that is sent as the first byte of each block read; reads run until a not-acknowledge.
// - After reset the read-length field is eight, and a block read sends eight as its first byte until the host writes another value;
// the engine starts each block read at the host-given index.
// - A block read first sends the read-length value, then consecutive register bytes from the host-given index, until the host answers with not-acknowledge.
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

`define SRB_IDX_PIN_LEVEL   8'h03
`define SRB_IDX_RSVD_FOUR   8'h04
`define SRB_IDX_REV_VENDOR  8'h05
`define SRB_IDX_PART        8'h06
`define SRB_IDX_READ_LEN    8'h07
`define SRB_IDX_RSVD_EIGHT  8'h08
`define SRB_READ_LEN_W      5
`define SRB_READ_LEN_RESET  5'h08
`define SRB_RSVD_BIT        1'b0
`define SRB_BYTE_ZERO       8'h00
`define SRB_BIT_CNT_ZERO    4'h0
`define SRB_BIT_CNT_ONE     4'h1
`define SRB_BITS_PER_BYTE   4'h8
`define SRB_LAST_TX_BIT     4'h7
`define SRB_INDEX_STEP      8'h01

`endif

// ===== src/srb_pkg.sv
// Types shared by the readback register bank and its bus engine.
`default_nettype none
package srb_pkg;

  // Live enable pin levels, one bit per output group.
  typedef struct packed {
    logic enable_pin_level_g12;
    logic enable_pin_level_g11;
    logic enable_pin_level_g10;
    logic enable_pin_level_g8;
    logic enable_pin_level_g7;
    logic enable_pin_level_g6;
    logic enable_pin_level_g5;
  } srb_pin_level_t;

  // One register write from the bus engine to the bank.
  typedef struct packed {
    logic       en;
    logic [7:0] index;
    logic [7:0] data;
  } srb_write_t;

  // Bus engine states.
  typedef enum logic [3:0] {
    SRB_IDLE       = 4'h0,
    SRB_ADDR       = 4'h1,
    SRB_ADDR_ACK   = 4'h2,
    SRB_INDEX      = 4'h3,
    SRB_INDEX_ACK  = 4'h4,
    SRB_WCNT       = 4'h5,
    SRB_WCNT_ACK   = 4'h6,
    SRB_WDATA      = 4'h7,
    SRB_WDATA_ACK  = 4'h8,
    SRB_TX         = 4'h9,
    SRB_TX_ACK     = 4'hA,
    SRB_WAIT       = 4'hB
  } srb_state_t;

endpackage
`default_nettype wire

// ===== src/srb_reg_bank.sv
// Register bank: pin readback, identification bytes and read-length register.
`timescale 1ns/100ps
`default_nettype none
`include "srb_params.svh"

module srb_reg_bank #(
  parameter logic [3:0] REVISION_CODE = 4'h3,  // Arbitrary value.
  parameter logic [3:0] VENDOR_CODE   = 4'h6,  // Arbitrary value.
  parameter logic [7:0] PART_CODE     = 8'h5A  // Arbitrary value.
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire srb_pkg::srb_pin_level_t pin_level,
  input  wire srb_pkg::srb_write_t    wr,
  input  wire logic [7:0]             rd_index,
  output logic [7:0]                  rd_data,
  output logic [`SRB_READ_LEN_W-1:0]  read_len
);
  import srb_pkg::*;

  logic [`SRB_READ_LEN_W-1:0] read_len_reg;
  logic [7:0]                 pin_byte;
  logic                       len_hit;

  assign pin_byte = {pin_level.enable_pin_level_g12,
                     pin_level.enable_pin_level_g11,
                     pin_level.enable_pin_level_g10,
                     `SRB_RSVD_BIT,
                     pin_level.enable_pin_level_g8,
                     pin_level.enable_pin_level_g7,
                     pin_level.enable_pin_level_g6,
                     pin_level.enable_pin_level_g5};

  // Only the read-length index accepts writes; all others drop them.
  assign len_hit  = wr.en && (wr.index == `SRB_IDX_READ_LEN);
  assign read_len = read_len_reg;

  // writable length field; resets to eight.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_len_reg <= `SRB_READ_LEN_RESET;
    end else if (len_hit) begin
      read_len_reg <= wr.data[`SRB_READ_LEN_W-1:0];
    end
  end

  // Read decode; indices outside this bank, reserved ones included, read zero.
  always_comb begin
    if (rd_index == `SRB_IDX_PIN_LEVEL) begin
      rd_data = pin_byte;
    end else if (rd_index == `SRB_IDX_REV_VENDOR) begin
      rd_data = {REVISION_CODE, VENDOR_CODE};
    end else if (rd_index == `SRB_IDX_PART) begin
      rd_data = PART_CODE;
    end else if (rd_index == `SRB_IDX_READ_LEN) begin
      rd_data = {{(8-`SRB_READ_LEN_W){`SRB_RSVD_BIT}}, read_len_reg};
    end else begin
      rd_data = `SRB_BYTE_ZERO;
    end
  end

endmodule
`default_nettype wire

// ===== tb/srb_smbus_regs_checker.sv
// Port assertions for the two-wire readback register bank.
`timescale 1ns/100ps
`default_nettype none
`include "srb_params.svh"
module srb_smbus_regs_checker (
  input wire logic                       CLK,
  input wire logic                       ARST_N,
  input wire logic                       SCL,
  input wire logic                       SDA_IN,
  input wire logic                       SDA_OUT,
  input wire logic                       SDA_OE,
  input wire srb_pkg::srb_pin_level_t    PIN_LEVEL,
  input wire logic [`SRB_READ_LEN_W-1:0] READ_LENGTH
);
  import srb_pkg::*;
  logic [3:0] low_cnt_reg;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // Counts cycles of low bus clock, saturating so it never wraps.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      low_cnt_reg <= 4'h0;
    else if (SCL)
      low_cnt_reg <= 4'h0;
    else if (low_cnt_reg != 4'hF)
      low_cnt_reg <= low_cnt_reg + 4'h1;
  end

  a_out_tied_low: assert property (SDA_OUT == 1'b0)
    else $error("Data output is not held low.");
  a_len_reset: assert property (
    $rose(ARST_N) |-> (READ_LENGTH == `SRB_READ_LEN_RESET) [*4])
    else $error("Read length is not eight after reset.");
  a_quiet_reset: assert property (
    $rose(ARST_N) |-> !SDA_OE [*4])
    else $error("Data line driven just after reset.");
  a_oe_after_fall: assert property (
    $changed(SDA_OE) |-> low_cnt_reg inside {[4'h2:4'h4]})
    else $error("Data drive changed away from clock fall.");
  a_hold_after_fall: assert property (
    $fell(SCL) |-> $stable(SDA_OE) [*2])
    else $error("Data drive changed too soon after fall.");
  a_ack_held: assert property (
    SDA_OE && $rose(SCL) |-> SDA_OE [*3])
    else $error("Driven bit dropped while clock high.");
  a_len_on_ack: assert property (
    $changed(READ_LENGTH) |-> SDA_OE && !SCL)
    else $error("Read length changed outside a write ack.");
  a_stop_quiet: assert property (
    SCL && $rose(SDA_IN) |=> !SDA_OE [*4])
    else $error("Data line driven after stop.");
endmodule

bind srb_smbus_regs srb_smbus_regs_checker srb_smbus_regs_checker_i (
  .CLK(CLK), .ARST_N(ARST_N), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .PIN_LEVEL(PIN_LEVEL),
  .READ_LENGTH(READ_LENGTH));
`default_nettype wire

// ===== tb/srb_host_model.sv
// Bus host model: drives the bus clock and pulls the data line low.
`timescale 1ns/100ps
`default_nettype none
module srb_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  logic [8:0] got;
  event       got_ev;

  // Idle bus: clock high, data left to its pull-up.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Changes land on falling edges so the slave never sees them mid-sample.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit: clock low 7 cycles, data set after 4, then high 6 cycles.
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(4);
    sda_low = ~b;
    tick(3);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(3);
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    scl = 1'b0;
    tick(4);
    sda_low = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
  endtask

  // Stop: data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    scl = 1'b0;
    tick(4);
    sda_low = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask

  // host answer.
  // A byte msb first; a ninth bit of 0 acks, 1 refuses or releases.
  task automatic xfer(input logic [7:0] d, input logic hb);
    for (int i = 8; i > 0; i--)
      bit_io(d[i-1], got[i]);
    bit_io(hb, got[0]);
    ->got_ev;
  endtask
endmodule
`default_nettype wire

// ===== tb/srb_smbus_regs_tb_top.sv
// Self-checking bench for the two-wire readback register bank.
`timescale 1ns/100ps
`default_nettype none
`include "srb_params.svh"
module srb_smbus_regs_tb_top;
  import srb_pkg::*;
  localparam logic [6:0] ADDR = 7'h2C;  // Arbitrary value.
  localparam logic [3:0] REV  = 4'h9;   // Arbitrary value.
  localparam logic [3:0] VEN  = 4'hC;   // Arbitrary value.
  localparam logic [7:0] PART = 8'hA7;  // Arbitrary value.
  logic                       clk;
  logic                       arst_n;
  logic                       scl;
  logic                       sda_low;
  logic                       sda_oe;
  logic                       sda_out;
  wire                        sda;
  srb_pin_level_t             pins;
  logic [`SRB_READ_LEN_W-1:0] read_len;
  logic [8:0]                 notes[$];
  logic [31:0]                seed;
  int                         failures;
  int                         comparisons;
  int                         cycles;

  // Open-drain wire with a pull-up: the device's level shows only while
  // it drives, and the host can always pull the line low.
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  srb_smbus_regs #(.DEV_ADDR(ADDR), .REVISION_CODE(REV),
    .VENDOR_CODE(VEN), .PART_CODE(PART)) srb_smbus_regs_i (
    .CLK(clk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .PIN_LEVEL(pins),
    .READ_LENGTH(read_len));
  srb_host_model srb_host_model_i (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected byte at an index, built from the register map.
  function automatic logic [7:0] reg_val(input logic [7:0] i,
                                         input logic [4:0] len);
    case (i)
      8'h03: return {pins.enable_pin_level_g12, pins.enable_pin_level_g11,
        pins.enable_pin_level_g10, 1'b0, pins.enable_pin_level_g8,
        pins.enable_pin_level_g7, pins.enable_pin_level_g6,
        pins.enable_pin_level_g5};
      8'h05: return {REV, VEN};
      8'h06: return PART;
      8'h07: return {3'h0, len};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Notes the expected byte and ack, then moves the byte on the bus.
  task automatic send(input logic [7:0] d, input logic hb,
                      input logic [8:0] exp);
    notes.push_back(exp);
    srb_host_model_i.xfer(d, hb);
  endtask

  // Indexed block read of n bytes; the host refuses the last one.
  task automatic block_read(input logic [7:0] idx, input int n,
                            input logic [4:0] len);
    logic [7:0] i;
    i = idx;
    srb_host_model_i.start();
    send({ADDR, 1'b0}, 1'b1, {ADDR, 2'b00});
    send(idx, 1'b1, {idx, 1'b0});
    srb_host_model_i.start();
    send({ADDR, 1'b1}, 1'b1, {ADDR, 2'b10});
    send(8'hFF, 1'b0, {3'h0, len, 1'b0});
    for (int k = 1; k <= n; k++) begin
      send(8'hFF, k == n, {reg_val(i, len), k == n});
      i = i + 8'h01;
    end
    srb_host_model_i.stop();
  endtask

  // Block write of two bytes from idx; the device acks every byte.
  task automatic block_write(input logic [7:0] idx, input logic [7:0] d);
    srb_host_model_i.start();
    send({ADDR, 1'b0}, 1'b1, {ADDR, 2'b00});
    send(idx, 1'b1, {idx, 1'b0});
    send(8'h02, 1'b1, {8'h02, 1'b0});
    send(d, 1'b1, {d, 1'b0});
    send(~d, 1'b1, {~d, 1'b0});
    srb_host_model_i.stop();
  endtask

  // Compares each finished bus byte with the oldest note.
  initial begin
    forever begin
      @(srb_host_model_i.got_ev);
      check("bus byte", notes.pop_front(), srb_host_model_i.got);
    end
  end

  // A full run takes about 9500 cycles; the ceiling leaves margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end

  // Main sequence: reset, reads, writes, refusal and a second reset.
  initial begin
    arst_n = 1'b0;
    pins = '0;
    seed = 32'h2F4B017E;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("read length", {4'h0, 5'h08}, {4'h0, read_len});
    block_read(8'h03, 7, 5'h08);
    seed = xs(seed);
    block_write(8'h07, 8'hFD);
    block_write(8'h03, seed[7:0]);
    block_write(8'h05, seed[15:8]);
    check("read length", {4'h0, 5'h1D}, {4'h0, read_len});
    srb_host_model_i.start();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1, {ADDR ^ 7'h01, 2'b01});
    srb_host_model_i.stop();
    for (int j = 1; j <= 4; j++) begin
      seed = xs(seed);
      pins = srb_pin_level_t'(seed[6:0]);
      block_read(8'h03, j + 5, 5'h1D);
    end
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    check("read length", {4'h0, 5'h08}, {4'h0, read_len});
    block_read(8'h07, 1, 5'h08);
    final_report();
  end
endmodule
`default_nettype wire
